// ==== hw/frame_buffer_run_control.sv ====
/*
 run control and status registers of a video frame buffer, reached over
 AXI4-Lite, with the buffer occupancy and drop/repeat decision logic.
 assumes the writer and reader datapaths pulse frame start and done events
 in the clock domain, and hold off a start while the matching stall is high.
*/
// Summary of operation
// - register port belongs to the writer or the reader side, chosen at build
// - every register is one 32-bit word
// - go bit at index 0; cleared go halts at the next frame start
// - go resets to zero with run control built in, one without
// - index 1 reads the running flag in bit 0, other bits zero
// - writer side: stored frame sets done flag bit 0 and raises irq
// - reader side: fully fetched frame sets done flag bit 0 and raises irq
// - writing one to done flag bit 0 clears it and drops irq
// - writer side: index 3 counts kept incoming frames
// - reader side: index 3 counts output frames that are not repeats
// - locked rate is only legal with dropping and repeating enabled
// - locked rate: triple buffer, regular drop pattern from rate ratio
// - unlocked: triple buffer, drops and repeats follow buffer occupancy
// - no drop/repeat: double buffer, stall input when full
// - indices 0 to 3 exist in every build variant
// - index 4 counts dropped frames on writer, repeated frames on reader
`timescale 1ns/10ps
`default_nettype none
`include "fb_run_cfg.svh"
module frame_buffer_run_control #(
    parameter bit WRITER_SIDE = 1'b1,
    parameter bit RUN_CTRL_EN = 1'b1,
    parameter bit LOCKED_RATE = 1'b0,
    parameter bit DROP_EN     = 1'b1,
    parameter bit REPEAT_EN   = 1'b1,
    parameter int CNT_W       = 32
) (
    input  wire logic                   clock,
    input  wire logic                   rst_b,
    input  wire fb_run_pkg::axil_req_t  axi_req,
    output var  fb_run_pkg::axil_rsp_t  axi_rsp,
    input  wire fb_run_pkg::frame_evt_t evt,
    output var  fb_run_pkg::frame_ctl_t ctl,
    output logic                        irq
);
    localparam bit DR = DROP_EN && REPEAT_EN;
    localparam logic [1:0] NBUF = DR ? `NBUF_TRIPLE : `NBUF_DOUBLE;
    localparam logic [1:0] FULL_AT = NBUF - 2'h1;
    localparam bit CFG_OK = !LOCKED_RATE || DR;
    localparam logic GO_RESET = RUN_CTRL_EN ? `GO_RESET_RTC : `GO_RESET_NO_RTC;

    function automatic logic [3:0] reg_idx(input logic [`ADDR_W-1:0] a);
        reg_idx = a[`ADDR_W-1:2];
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0]  s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    logic                   awready_q;
    logic                   wready_q;
    logic                   bvalid_q;
    logic [1:0]             bresp_q;
    logic                   arready_q;
    logic                   rvalid_q;
    logic [31:0]            rdata_q;
    logic [1:0]             rresp_q;
    logic [`ADDR_W-1:0]     aw_addr_q;
    logic [31:0]            w_data_q;
    logic [3:0]             w_strb_q;
    logic [`ADDR_W-1:0]     ar_addr_q;
    logic                   go_q;
    fb_run_pkg::run_state_t run_state_q;
    logic                   done_flag_q;
    logic                   mask_q;
    logic [15:0]            in_rate_q;
    logic [15:0]            out_rate_q;
    logic [16:0]            phase_q;
    logic [1:0]             avail_q;
    logic [1:0]             avail_d;
    logic                   writing_q;
    logic [CNT_W-1:0]       kept_cnt_q;
    logic [CNT_W-1:0]       drep_cnt_q;
    logic                   in_keep_q;
    logic                   in_drop_q;
    logic                   in_stall_q;
    logic                   out_new_q;
    logic                   out_rep_q;
    logic                   out_stall_q;
    logic                   irq_q;
    logic [31:0]            rd_mux;
    logic                   rd_hit;

    assign axi_rsp = '{awready: awready_q, wready: wready_q, bvalid: bvalid_q,
                       bresp: bresp_q, arready: arready_q, rvalid: rvalid_q,
                       rdata: rdata_q, rresp: rresp_q};
    assign ctl = '{go: go_q, in_keep: in_keep_q, in_drop: in_drop_q,
                   in_stall: in_stall_q, out_new: out_new_q,
                   out_repeat: out_rep_q, out_stall: out_stall_q};
    assign irq = irq_q;

    // bus handshakes; a write commits once both address and data are held
    wire aw_hs = axi_req.awvalid && awready_q;
    wire w_hs  = axi_req.wvalid && wready_q;
    wire b_hs  = bvalid_q && axi_req.bready;
    wire ar_hs = axi_req.arvalid && arready_q;
    wire r_hs  = rvalid_q && axi_req.rready;
    wire wr_go = !awready_q && !wready_q && !bvalid_q;
    wire rd_go = !arready_q && !rvalid_q;
    wire [3:0] wr_idx = reg_idx(aw_addr_q);
    wire [3:0] rd_idx = reg_idx(ar_addr_q);
    wire wr_lane0 = wr_go && w_strb_q[0];

    wire wr_mapped = (wr_idx <= `IDX_DROP_REP_COUNT) || (wr_idx == `IDX_IN_RATE) ||
                     (wr_idx == `IDX_OUT_RATE) || (wr_idx == `IDX_IRQ_MASK);

    // the side that owns the registers is gated by go; the other runs freely
    wire in_gate  = WRITER_SIDE ? go_q : 1'b1;
    wire out_gate = WRITER_SIDE ? 1'b1 : go_q;
    wire ctl_start = WRITER_SIDE ? evt.in_start : evt.out_start;
    wire acc_in  = evt.in_start && in_gate;
    wire acc_out = evt.out_start && out_gate;

    // locked rate: keep when the phase accumulator crosses the input rate
    wire [16:0] phase_sum = phase_q + {1'b0, out_rate_q};
    wire lock_keep = phase_sum >= {1'b0, in_rate_q};
    wire full = avail_q >= FULL_AT;
    wire in_drop_w = acc_in && ((DROP_EN && full) || (LOCKED_RATE && !lock_keep));
    wire in_keep_w = acc_in && !in_drop_w;
    wire stored = evt.in_done && writing_q;
    wire out_new_w = acc_out && (avail_q != 2'h0);
    // with repeating off the reader is stalled, so an empty start only
    // happens if the datapath ignores the stall; it is counted as a repeat
    wire out_rep_w = acc_out && (avail_q == 2'h0);

    wire kept_ev = WRITER_SIDE ? in_keep_w : out_new_w;
    wire drep_ev = WRITER_SIDE ? in_drop_w : out_rep_w;
    wire done_ev = WRITER_SIDE ? stored : evt.out_done;
    wire done_clr = wr_lane0 && (wr_idx == `IDX_FRAME_DONE_IRQ) &&
                    w_data_q[`BIT_FRAME_DONE];

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            awready_q <= 1'b1;
            aw_addr_q <= '0;
        end else if (aw_hs) begin
            awready_q <= 1'b0;
            aw_addr_q <= axi_req.awaddr;
        end else if (b_hs) begin
            awready_q <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wready_q <= 1'b1;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else if (w_hs) begin
            wready_q <= 1'b0;
            w_data_q <= axi_req.wdata;
            w_strb_q <= axi_req.wstrb;
        end else if (b_hs) begin
            wready_q <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
        end else if (b_hs) begin
            bvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            arready_q <= 1'b1;
            ar_addr_q <= '0;
        end else if (ar_hs) begin
            arready_q <= 1'b0;
            ar_addr_q <= axi_req.araddr;
        end else if (r_hs) begin
            arready_q <= 1'b1;
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case (rd_idx)
            `IDX_RUN_CONTROL:    rd_mux[`BIT_GO] = go_q;
            `IDX_RUN_STATUS:     rd_mux[`BIT_RUNNING] = (run_state_q == fb_run_pkg::RUNNING);
            `IDX_FRAME_DONE_IRQ: rd_mux[`BIT_FRAME_DONE] = done_flag_q;
            `IDX_KEPT_COUNT:     rd_mux = 32'(kept_cnt_q);
            `IDX_DROP_REP_COUNT: rd_mux = 32'(drep_cnt_q);
            `IDX_IN_RATE:        rd_mux[15:0] = in_rate_q;
            `IDX_OUT_RATE:       rd_mux[15:0] = out_rate_q;
            `IDX_IRQ_MASK:       rd_mux[`BIT_FRAME_DONE] = mask_q;
            default:             rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= `RESP_OKAY;
        end else if (rd_go) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_mux;
            rresp_q  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (r_hs) begin
            rvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            go_q <= GO_RESET;
        end else if (wr_lane0 && wr_idx == `IDX_RUN_CONTROL) begin
            go_q <= w_data_q[`BIT_GO];
        end
    end

    // go is only looked at when control information is read at frame start
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            run_state_q <= fb_run_pkg::HALTED;
        end else if (ctl_start) begin
            run_state_q <= go_q ? fb_run_pkg::RUNNING : fb_run_pkg::HALTED;
        end
    end

    // rate registers only matter to a locked build
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            in_rate_q  <= `RATE_RESET;
            out_rate_q <= `RATE_RESET;
        end else if (wr_go && wr_idx == `IDX_IN_RATE) begin
            in_rate_q  <= merge16(in_rate_q, w_data_q, w_strb_q);
        end else if (wr_go && wr_idx == `IDX_OUT_RATE) begin
            out_rate_q <= merge16(out_rate_q, w_data_q, w_strb_q);
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            phase_q <= '0;
        end else if (LOCKED_RATE && acc_in) begin
            phase_q <= lock_keep ? phase_sum - {1'b0, in_rate_q} : phase_sum;
        end
    end

    // set wins over a clear in the same cycle so no frame event is lost
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            done_flag_q <= 1'b0;
        end else if (done_ev) begin
            done_flag_q <= 1'b1;
        end else if (done_clr) begin
            done_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            mask_q <= 1'b0;
        end else if (wr_lane0 && wr_idx == `IDX_IRQ_MASK) begin
            mask_q <= w_data_q[`BIT_FRAME_DONE];
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= done_flag_q && mask_q;
        end
    end

    always_comb begin
        avail_d = avail_q;
        if (stored && !out_new_w) begin
            avail_d = avail_q + 2'h1;
        end else if (!stored && out_new_w) begin
            avail_d = avail_q - 2'h1;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            avail_q   <= 2'h0;
            writing_q <= 1'b0;
        end else begin
            avail_q <= avail_d;
            if (in_keep_w) begin
                writing_q <= 1'b1;
            end else if (evt.in_done) begin
                writing_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            kept_cnt_q <= '0;
            drep_cnt_q <= '0;
        end else begin
            if (kept_ev) begin
                kept_cnt_q <= kept_cnt_q + 1'b1;
            end
            if (drep_ev) begin
                drep_cnt_q <= drep_cnt_q + 1'b1;
            end
        end
    end

    // double buffer holds the input back instead of dropping
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            in_keep_q   <= 1'b0;
            in_drop_q   <= 1'b0;
            in_stall_q  <= 1'b0;
            out_new_q   <= 1'b0;
            out_rep_q   <= 1'b0;
            out_stall_q <= !REPEAT_EN;
        end else begin
            in_keep_q   <= in_keep_w;
            in_drop_q   <= in_drop_w;
            in_stall_q  <= !DROP_EN && (avail_d >= FULL_AT);
            out_new_q   <= out_new_w;
            out_rep_q   <= out_rep_w;
            out_stall_q <= !REPEAT_EN && (avail_d == 2'h0);
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    sequence s_write_held;
        !awready_q && !wready_q && !bvalid_q;
    endsequence
    sequence s_resp_out;
        bvalid_q && (bresp_q == (wr_mapped ? `RESP_OKAY : `RESP_SLVERR));
    endsequence

    a_cfg_legal: assert property (CFG_OK)
        else $error("locked rate built without drop and repeat");
    a_go_reset: assert property ($rose(rst_b) |-> go_q == GO_RESET)
        else $error("go bit has wrong reset value");
    a_halt_start: assert property (ctl_start && !go_q |=> run_state_q == fb_run_pkg::HALTED)
        else $error("side kept running after go was cleared");
    a_status_read: assert property (rd_go && rd_idx == `IDX_RUN_STATUS |=>
        rdata_q == {31'h0000_0000, $past(run_state_q == fb_run_pkg::RUNNING)})
        else $error("status read does not show running flag");
    a_done_sets: assert property (done_ev |=> done_flag_q ##1 (irq_q == $past(mask_q)))
        else $error("frame done did not raise flag and irq");
    a_done_clear: assert property (done_clr && !done_ev |=> !done_flag_q ##1 !irq_q)
        else $error("w1c did not clear flag and irq");
    a_kept_count: assert property (kept_ev |=> kept_cnt_q == $past(kept_cnt_q) + 1'b1)
        else $error("kept frame counter did not step");
    a_drep_count: assert property (drep_ev |=> drep_cnt_q == $past(drep_cnt_q) + 1'b1)
        else $error("drop/repeat counter did not step");
    a_buf_bound: assert property (avail_q <= FULL_AT)
        else $error("buffer occupancy beyond capacity");
    a_write_resp: assert property (s_write_held |=> s_resp_out[*1] ##0 !awready_q)
        else $error("write response missing or wrong");
endmodule // frame_buffer_run_control
`default_nettype wire

// ==== hw/fb_run_cfg.svh ====
/*
 holds register indices, field positions, reset values and buffer counts
 of the frame buffer run control block as macros.
 assumes inclusion by bare name from the package and the design module.
*/
`ifndef FB_RUN_CFG_SVH
`define FB_RUN_CFG_SVH
`define ADDR_W             6
`define IDX_RUN_CONTROL    4'h0
`define IDX_RUN_STATUS     4'h1
`define IDX_FRAME_DONE_IRQ 4'h2
`define IDX_KEPT_COUNT     4'h3
`define IDX_DROP_REP_COUNT 4'h4
`define IDX_IN_RATE        4'hA
`define IDX_OUT_RATE       4'hB
`define IDX_IRQ_MASK       4'hC
`define BIT_GO             0
`define BIT_RUNNING        0
`define BIT_FRAME_DONE     0
`define GO_RESET_RTC       1'b0
`define GO_RESET_NO_RTC    1'b1
`define RATE_RESET         16'h0001
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2
`define NBUF_TRIPLE        2'h3
`define NBUF_DOUBLE        2'h2
`endif

// ==== hw/fb_run_pkg.sv ====
/*
 holds the types of the frame buffer run control block: bus request and
 response bundles, frame events, frame decisions and the run state.
 assumes fb_run_cfg.svh on the include path.
*/
`default_nettype none
`include "fb_run_cfg.svh"
package fb_run_pkg;
    typedef struct packed {
        logic                awvalid;
        logic [`ADDR_W-1:0]  awaddr;
        logic [2:0]          awprot;
        logic                wvalid;
        logic [31:0]         wdata;
        logic [3:0]          wstrb;
        logic                bready;
        logic                arvalid;
        logic [`ADDR_W-1:0]  araddr;
        logic [2:0]          arprot;
        logic                rready;
    } axil_req_t;
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axil_rsp_t;
    typedef struct packed {
        logic in_start;
        logic in_done;
        logic out_start;
        logic out_done;
    } frame_evt_t;
    typedef struct packed {
        logic go;
        logic in_keep;
        logic in_drop;
        logic in_stall;
        logic out_new;
        logic out_repeat;
        logic out_stall;
    } frame_ctl_t;
    typedef enum logic {HALTED, RUNNING} run_state_t;
endpackage
`default_nettype wire

// ==== tb/axil_host.sv ====
/*
 host processor model: an AXI4-Lite master with one write and one read task.
 assumes the slave answers on registered outputs and the clock is shared.
*/
`timescale 1ns/10ps
`default_nettype none
`include "fb_run_cfg.svh"
module axil_host (
    input  wire logic                  clock,
    output var  fb_run_pkg::axil_req_t axi_req,
    input  wire fb_run_pkg::axil_rsp_t axi_rsp
);
    initial axi_req = '0;

    // address and data offered together, each dropped when taken
    task automatic write(input logic [`ADDR_W-1:0] addr, input logic [31:0] data,
                         output logic [1:0] resp);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge clock);
        axi_req.awvalid <= 1'b1;
        axi_req.awaddr  <= addr;
        axi_req.wvalid  <= 1'b1;
        axi_req.wdata   <= data;
        axi_req.wstrb   <= 4'hF;
        axi_req.bready  <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge clock);
            if (!aw_done && axi_rsp.awready) begin
                aw_done = 1'b1;
                axi_req.awvalid <= 1'b0;
            end
            if (!w_done && axi_rsp.wready) begin
                w_done = 1'b1;
                axi_req.wvalid <= 1'b0;
            end
        end
        do @(posedge clock); while (!axi_rsp.bvalid);
        resp = axi_rsp.bresp;
        axi_req.bready <= 1'b0;
    endtask

    task automatic read(input logic [`ADDR_W-1:0] addr, output logic [31:0] data,
                        output logic [1:0] resp);
        @(posedge clock);
        axi_req.arvalid <= 1'b1;
        axi_req.araddr  <= addr;
        axi_req.rready  <= 1'b1;
        do @(posedge clock); while (!axi_rsp.arready);
        axi_req.arvalid <= 1'b0;
        do @(posedge clock); while (!axi_rsp.rvalid);
        data = axi_rsp.rdata;
        resp = axi_rsp.rresp;
        axi_req.rready <= 1'b0;
    endtask
endmodule // axil_host
`default_nettype wire

// ==== tb/tb.sv ====
/*
 self-checking bench of the run control block: default writer-side build,
 then a locked reader-side build and a double buffer after a second reset.
 assumes run control built in on every instance.
*/
`timescale 1ns/10ps
`default_nettype none
`include "fb_run_cfg.svh"
module tb;
    logic                   clock;
    logic                   rst_b;
    fb_run_pkg::axil_req_t  axi_req;
    fb_run_pkg::axil_rsp_t  axi_rsp;
    fb_run_pkg::frame_evt_t evt;
    fb_run_pkg::frame_ctl_t ctl;
    logic                   irq;
    int                     mismatches;
    int                     compares;
    logic [31:0]            rdata;
    logic [1:0]             resp;
    logic                   side2;
    fb_run_pkg::axil_req_t  axi_req_rd;
    fb_run_pkg::axil_rsp_t  axi_rsp_rd;
    fb_run_pkg::frame_ctl_t ctl_rd;
    logic                   irq_rd;
    fb_run_pkg::frame_evt_t evt_dbl;
    fb_run_pkg::frame_ctl_t ctl_dbl;

    initial clock = 1'b0;
    always #5 clock = ~clock;

    axil_host u_host (.clock(clock), .axi_req(axi_req), .axi_rsp(axi_rsp));

    frame_buffer_run_control uut (
        .clock   (clock),
        .rst_b   (rst_b),
        .axi_req (axi_req),
        .axi_rsp (axi_rsp),
        .evt     (evt),
        .ctl     (ctl),
        .irq     (irq)
    );

    axil_host u_host_rd (.clock(clock), .axi_req(axi_req_rd), .axi_rsp(axi_rsp_rd));

    frame_buffer_run_control #(.WRITER_SIDE(1'b0), .LOCKED_RATE(1'b1)) uut_rd (
        .clock   (clock),
        .rst_b   (rst_b),
        .axi_req (axi_req_rd),
        .axi_rsp (axi_rsp_rd),
        .evt     (evt),
        .ctl     (ctl_rd),
        .irq     (irq_rd)
    );

    // shadows the reader build's bus, so it sees the same register writes
    frame_buffer_run_control #(.DROP_EN(1'b0), .REPEAT_EN(1'b0)) uut_dbl (
        .clock   (clock),
        .rst_b   (rst_b),
        .axi_req (axi_req_rd),
        .axi_rsp (),
        .evt     (evt_dbl),
        .ctl     (ctl_dbl),
        .irq     ()
    );

    // far side of the double buffer never starts into a stall
    assign evt_dbl = '{in_start: evt.in_start && !ctl_dbl.in_stall, in_done: evt.in_done,
                       out_start: evt.out_start && !ctl_dbl.out_stall, out_done: evt.out_done};

    function automatic logic [3:0] dec(input fb_run_pkg::frame_ctl_t c);
        return {c.in_keep, c.in_drop, c.out_new, c.out_repeat};
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rd(input logic [5:0] addr, input logic [31:0] exp, input logic [1:0] er);
        if (side2)
            u_host_rd.read(addr, rdata, resp);
        else
            u_host.read(addr, rdata, resp);
        check("read data", rdata, exp);
        check("read resp", {30'h0000_0000, resp}, {30'h0000_0000, er});
    endtask

    task automatic wr(input logic [5:0] addr, input logic [31:0] data);
        if (side2)
            u_host_rd.write(addr, data, resp);
        else
            u_host.write(addr, data, resp);
        check("write resp", {30'h0000_0000, resp}, {30'h0000_0000, `RESP_OKAY});
    endtask

    // events as {in_start, in_done, out_start, out_done}
    // decisions as {in_keep, in_drop, out_new, out_repeat}
    task automatic pulse(input logic [3:0] e, input logic [3:0] exp);
        @(posedge clock);
        evt <= fb_run_pkg::frame_evt_t'(e);
        @(posedge clock);
        evt <= '0;
        #1;
        check("decision", dec(side2 ? ctl_rd : ctl), exp);
    endtask

    task automatic irq_after(input int n, input logic exp);
        repeat (n) @(posedge clock);
        #1;
        check("irq", side2 ? irq_rd : irq, exp);
    endtask

    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // whole run is a few hundred cycles
    initial begin
        #50us;
        mismatches++;
        summarize();
    end

    initial begin
        rst_b = 1'b0;
        evt = '0;
        side2 = 1'b0;
        mismatches = 0;
        compares = 0;
        repeat (8) @(posedge clock);
        rst_b <= 1'b1;
        #1;
        check("go", ctl.go, `GO_RESET_RTC);
        check("irq", irq, 1'b0);
        for (int i = 0; i < 5; i++) begin
            rd(6'(4 * i), 32'h0000_0000, `RESP_OKAY);
        end
        rd(6'h1C, 32'h0000_0000, `RESP_SLVERR);
        $display("test reset done");

        pulse(4'h8, 4'h0);
        rd(6'h04, 32'h0000_0000, `RESP_OKAY);
        rd(6'h0C, 32'h0000_0000, `RESP_OKAY);
        $display("test halted done");

        wr(6'h00, 32'h0000_0001);
        check("go", ctl.go, 1'b1);
        rd(6'h00, 32'h0000_0001, `RESP_OKAY);
        pulse(4'h8, 4'h8);
        rd(6'h04, 32'h0000_0001, `RESP_OKAY);
        wr(6'h0C, 32'hFFFF_FFFF);
        rd(6'h0C, 32'h0000_0001, `RESP_OKAY);
        $display("test run done");

        pulse(4'h4, 4'h0);
        rd(6'h08, 32'h0000_0001, `RESP_OKAY);
        check("irq", irq, 1'b0);
        wr(6'h30, 32'h0000_0001);
        irq_after(2, 1'b1);
        wr(6'h08, 32'h0000_0001);
        rd(6'h08, 32'h0000_0000, `RESP_OKAY);
        irq_after(1, 1'b0);
        $display("test irq done");

        pulse(4'h8, 4'h8);
        pulse(4'h4, 4'h0);
        check("in stall", ctl.in_stall, 1'b0);
        pulse(4'h8, 4'h4);
        pulse(4'h4, 4'h0);
        rd(6'h0C, 32'h0000_0002, `RESP_OKAY);
        rd(6'h10, 32'h0000_0001, `RESP_OKAY);
        $display("test drop done");

        // dropped frame must not have been stored: two new, then a repeat
        pulse(4'h2, 4'h2);
        pulse(4'h2, 4'h2);
        pulse(4'h2, 4'h1);
        rd(6'h10, 32'h0000_0001, `RESP_OKAY);
        $display("test reader done");

        wr(6'h28, 32'h0000_003C);
        wr(6'h2C, 32'h0000_0018);
        rd(6'h28, 32'h0000_003C, `RESP_OKAY);
        rd(6'h2C, 32'h0000_0018, `RESP_OKAY);
        $display("test rate done");

        wr(6'h00, 32'h0000_0000);
        pulse(4'h8, 4'h0);
        rd(6'h04, 32'h0000_0000, `RESP_OKAY);
        rd(6'h0C, 32'h0000_0002, `RESP_OKAY);
        $display("test stop done");

        // second reset clears the occupancy the shared events left behind
        rst_b <= 1'b0;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        #1;
        side2 = 1'b1;
        check("go", ctl_rd.go, `GO_RESET_RTC);
        check("out stall", ctl_dbl.out_stall, 1'b1);
        wr(6'h28, 32'h0000_003C);
        wr(6'h2C, 32'h0000_0018);
        pulse(4'h8, 4'h4);
        pulse(4'h8, 4'h4);
        pulse(4'h8, 4'h8);
        pulse(4'h4, 4'h0);
        pulse(4'h2, 4'h0);
        rd(6'h04, 32'h0000_0000, `RESP_OKAY);
        wr(6'h00, 32'h0000_0001);
        pulse(4'h2, 4'h2);
        pulse(4'h2, 4'h1);
        pulse(4'h1, 4'h0);
        rd(6'h08, 32'h0000_0001, `RESP_OKAY);
        rd(6'h0C, 32'h0000_0001, `RESP_OKAY);
        rd(6'h10, 32'h0000_0001, `RESP_OKAY);
        rd(6'h04, 32'h0000_0001, `RESP_OKAY);
        wr(6'h30, 32'h0000_0001);
        irq_after(2, 1'b1);
        check("in stall", ctl_dbl.in_stall, 1'b0);
        pulse(4'h8, 4'h4);
        pulse(4'h4, 4'h0);
        check("in stall", ctl_dbl.in_stall, 1'b1);
        check("out stall", ctl_dbl.out_stall, 1'b0);
        $display("test reader side done");
        summarize();
    end
endmodule // tb
`default_nettype wire
